// File: verilog/ibi_core.sv
/*
 * Bus-side logic of an instrument bus port: controller, talker and
 * listener roles, three-wire interlocked byte handshake, management lines.
 * Assumes the cable transceivers sit outside; every bus pin is split into
 * input, output and output enable, and the inputs are synchronous to clk.
 */
`timescale 1ns/1ps

// Overview of operation
// - Sixteen signal lines: eight data, three handshake, five management.
// - Data lines carry commands and data; bit eight optional parity in 7-bit mode.
// - Every byte crosses by an asynchronous interlocked three-wire handshake.
// - Not-ready-for-data is driven by all during commands, Listeners during data.
// - Not-data-accepted is driven by all during commands, Listeners during data.
// - Data-valid asserts only with stable data; Controller for commands, Talker data.
// - Controller asserts attention for commands, releases it for Talker data.
// - System Controller pulses interface clear to reset the bus and take charge.
// - Only the System Controller drives remote enable.
// - Any device may request service; the controller in charge watches it. This port never pulls srq_l low.
// - Talker asserts end-or-identify with the last byte of a message.
// - Controller uses end-or-identify with attention to start a parallel poll.
// - One controller in charge; only the System Controller seizes control.
// - All lines are negative logic: low is true, high is false.
// - Controller addresses Talker and Listeners before data, unaddresses after.
// - Talk-only to listen-only operation works with no controller.
// - Port can be Controller, Talker or Listener.
module ibi_core #(
  parameter int IFC_CYCLES = ibi_pkg::IFC_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Port configuration
  input  wire logic                 sys_ctrl,
  input  wire ibi_pkg::ibi_role_type role,
  input  wire logic                 parity_en,
  // Controller requests
  input  wire logic                 ifc_req,
  input  wire logic                 ren_set,
  input  wire logic                 ren_clr,
  input  wire logic                 cic_pass,
  input  wire logic                 ppoll_req,
  // Transmit stream
  input  wire logic                 tx_valid,
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_last,
  input  wire logic                 tx_cmd,
  output logic                      tx_ready,
  // Receive stream
  output logic                      rx_valid,
  output logic [7:0]                rx_data,
  output logic                      rx_end,
  output logic                      rx_cmd,
  input  wire logic                 rx_ready,
  // Status
  output logic                      cic,
  output logic                      srq_pending,
  output logic                      ren_active,
  output logic                      parity_ok,
  // Bus pins, levels as on the wire
  input  wire ibi_pkg::ibi_bus_type bus_i,
  output ibi_pkg::ibi_bus_type      bus_o,
  output ibi_pkg::ibi_bus_type      bus_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  ibi_pkg::ibi_state_type st_r;
  ibi_pkg::ibi_state_type st_nxt;

  logic atn_on;
  logic dav_on;
  logic nrfd_on;
  logic ndac_on;
  logic eoi_on;
  logic ifc_on;
  logic srq_on;
  logic acceptor;
  logic sourcing;

  // Negative logic: a low wire level is the true state
  function automatic logic asserted(input logic lvl);
    return ~lvl;
  endfunction

  always_comb begin
    atn_on  = asserted(bus_i.atn_l);
    dav_on  = asserted(bus_i.dav_l);
    nrfd_on = asserted(bus_i.nrfd_l);
    ndac_on = asserted(bus_i.ndac_l);
    eoi_on  = asserted(bus_i.eoi_l);
    ifc_on  = asserted(bus_i.ifc_l);
    srq_on  = asserted(bus_i.srq_l);
  end

  // Under attention every device accepts; else only a listener
  assign acceptor = atn_on || (role == ibi_pkg::ROLE_LISTEN);
  // Commands only from the controller in charge; data from the talker
  assign sourcing = st_r.tx_cmd ? st_r.cic : (role == ibi_pkg::ROLE_TALK);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;

    // Interface clear: only a system controller pulses it
    if (st_r.ifc_busy) begin
      if (st_r.cnt == 16'(IFC_CYCLES - 1)) begin
        st_nxt.ifc_busy = 1'b0;
        st_nxt.cnt      = ibi_pkg::CNT_ZERO;
        st_nxt.cic      = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end else if (ifc_req && sys_ctrl && st_r.src == ibi_pkg::SRC_IDLE && !tx_valid) begin
      // Counter is shared with the settle delay, so clear starts only while idle
      st_nxt.ifc_busy = 1'b1;
      st_nxt.cnt      = ibi_pkg::CNT_ZERO;
    end

    // Another controller's clear takes charge away from us
    if (ifc_on && !st_r.ifc_busy) begin
      st_nxt.cic = 1'b0;
    end
    if (cic_pass && st_r.cic && st_r.src == ibi_pkg::SRC_IDLE) begin
      st_nxt.cic = 1'b0;
      st_nxt.atn = 1'b0;
    end

    if (ren_set && sys_ctrl) begin
      st_nxt.ren = 1'b1;
    end else if (ren_clr || !sys_ctrl) begin
      st_nxt.ren = 1'b0;
    end

    st_nxt.ppoll    = ppoll_req && st_r.cic && st_r.src == ibi_pkg::SRC_IDLE;
    st_nxt.srq_seen = st_r.cic && srq_on;

    // Source side of the handshake
    unique case (st_r.src)
      ibi_pkg::SRC_IDLE: begin
        if (tx_valid && !st_r.ifc_busy) begin
          st_nxt.tx_byte = tx_data;
          st_nxt.tx_eoi  = tx_last && !tx_cmd;
          st_nxt.tx_cmd  = tx_cmd;
          st_nxt.atn     = tx_cmd && st_r.cic;
          st_nxt.src     = ibi_pkg::SRC_WAIT_RDY;
        end
      end
      ibi_pkg::SRC_WAIT_RDY: begin
        if (!sourcing) begin
          st_nxt.src = ibi_pkg::SRC_IDLE;
        end else if (!nrfd_on) begin
          st_nxt.src = ibi_pkg::SRC_SETTLE;
          st_nxt.cnt = ibi_pkg::CNT_ZERO;
        end
      end
      ibi_pkg::SRC_SETTLE: begin
        if (st_r.cnt == 16'(ibi_pkg::SETTLE_CYC - 1)) begin
          st_nxt.src = ibi_pkg::SRC_WAIT_ACC;
          st_nxt.cnt = ibi_pkg::CNT_ZERO;
        end else begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      end
      ibi_pkg::SRC_WAIT_ACC: begin
        if (!ndac_on) begin
          st_nxt.src = ibi_pkg::SRC_RELEASE;
        end
      end
      ibi_pkg::SRC_RELEASE: begin
        st_nxt.src = ibi_pkg::SRC_IDLE;
      end
      default: begin
        st_nxt.src = ibi_pkg::SRC_IDLE;
      end
    endcase

    // Acceptor side of the handshake
    if (st_r.rx_valid && rx_ready) begin
      st_nxt.rx_valid = 1'b0;
    end
    unique case (st_r.acc)
      ibi_pkg::ACC_READY: begin
        if (acceptor && dav_on && !st_r.rx_valid) begin
          st_nxt.rx_byte  = bus_i.dio_l ^ 8'hFF;
          st_nxt.rx_eoi   = eoi_on && !atn_on;
          st_nxt.rx_cmd   = atn_on;
          st_nxt.rx_valid = 1'b1;
          st_nxt.acc      = ibi_pkg::ACC_TAKE;
        end
      end
      ibi_pkg::ACC_TAKE: begin
        st_nxt.acc = ibi_pkg::ACC_WAIT_DROP;
      end
      ibi_pkg::ACC_WAIT_DROP: begin
        if (!dav_on) begin
          st_nxt.acc = ibi_pkg::ACC_READY;
        end
      end
      default: begin
        st_nxt.acc = ibi_pkg::ACC_READY;
      end
    endcase
    if (!acceptor && st_r.acc == ibi_pkg::ACC_WAIT_DROP && !dav_on) begin
      st_nxt.acc = ibi_pkg::ACC_READY;
    end

    // Drop attention between frames so a talker may send
    if (st_r.src == ibi_pkg::SRC_IDLE && !tx_valid && !(tx_cmd && st_r.cic)) begin
      st_nxt.atn = st_r.atn && st_r.cic && tx_cmd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Pin drive, open collector style: enable only to pull low
  // ****************************************************************
  logic drive_data;
  logic not_ready;
  logic not_accepted;

  assign drive_data   = st_r.src == ibi_pkg::SRC_SETTLE || st_r.src == ibi_pkg::SRC_WAIT_ACC;
  assign not_ready    = acceptor && (st_r.acc != ibi_pkg::ACC_READY || st_r.rx_valid);
  assign not_accepted = acceptor && st_r.acc != ibi_pkg::ACC_TAKE
                        && st_r.acc != ibi_pkg::ACC_WAIT_DROP;

  always_comb begin
    bus_o        = '0;
    bus_oe       = '0;
    bus_oe.dio_l = drive_data ? st_r.tx_byte : 8'h00;
    bus_oe.dav_l = st_r.src == ibi_pkg::SRC_WAIT_ACC;
    bus_oe.nrfd_l = not_ready;
    bus_oe.ndac_l = not_accepted;
    bus_oe.atn_l = st_r.atn || st_r.ppoll;
    bus_oe.eoi_l = (drive_data && st_r.tx_eoi) || st_r.ppoll;
    bus_oe.ifc_l = st_r.ifc_busy;
    bus_oe.ren_l = st_r.ren;
    bus_oe.srq_l = 1'b0;
  end

  // ****************************************************************
  // User side
  // ****************************************************************
  assign tx_ready    = st_r.src == ibi_pkg::SRC_IDLE && !st_r.ifc_busy;
  assign rx_valid    = st_r.rx_valid;
  // Parity bit passes through; caller may mask it in 7-bit mode
  assign rx_data     = st_r.rx_byte;
  assign rx_end      = st_r.rx_eoi;
  assign rx_cmd      = st_r.rx_cmd;
  assign cic         = st_r.cic;
  assign srq_pending = st_r.srq_seen;
  assign ren_active  = st_r.ren;
  assign parity_ok   = !parity_en || !(^st_r.rx_byte);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ready_seen;
    st_r.src == ibi_pkg::SRC_WAIT_RDY && sourcing && !nrfd_on;
  endsequence

  a_dav_after_settle: assert property (@(posedge clk) disable iff (!rst_n)
    s_ready_seen |-> ##1 !bus_oe.dav_l [*5] ##1 bus_oe.dav_l)
    else $error("data valid not after settle");

  a_dav_needs_data: assert property (@(posedge clk) disable iff (!rst_n)
    bus_oe.dav_l |-> $past(drive_data) && bus_oe.dio_l == st_r.tx_byte)
    else $error("data valid without stable data");

  a_dav_drop_acc: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_oe.dav_l && !ndac_on) |=> !bus_oe.dav_l)
    else $error("data valid held after accept");

  a_ifc_only_sys: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st_r.ifc_busy) |-> $past(sys_ctrl) && $past(ifc_req))
    else $error("clear pulsed by non system controller");

  a_ren_only_sys: assert property (@(posedge clk) disable iff (!rst_n)
    bus_oe.ren_l |-> $past(sys_ctrl))
    else $error("remote enable without system controller");

  a_atn_only_cic: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st_r.atn) |-> $past(st_r.cic) && $past(tx_cmd))
    else $error("attention raised outside charge");

  a_eoi_data_only: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_oe.eoi_l && !st_r.ppoll) |-> !st_r.tx_cmd && st_r.tx_eoi)
    else $error("end marker on command byte");

  a_ppoll_pair: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.ppoll |-> bus_oe.atn_l && bus_oe.eoi_l)
    else $error("poll without attention and end");

  a_cic_gain: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st_r.cic) |-> $past(st_r.ifc_busy) && sys_ctrl)
    else $error("charge taken without clear");

  a_rx_take_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.acc == ibi_pkg::ACC_READY && atn_on && dav_on && !st_r.rx_valid)
      |=> st_r.rx_valid && st_r.rx_cmd)
    else $error("command byte not taken under attention");

  sequence s_data_offer;
    st_r.acc == ibi_pkg::ACC_READY && !atn_on && role == ibi_pkg::ROLE_LISTEN && dav_on && !st_r.rx_valid;
  endsequence

  a_rx_take_data: assert property (@(posedge clk) disable iff (!rst_n)
    s_data_offer |=> st_r.rx_valid && !st_r.rx_cmd)
    else $error("data byte not taken by listener");

  a_nrfd_unread: assert property (@(posedge clk) disable iff (!rst_n)
    (acceptor && st_r.rx_valid) |-> bus_oe.nrfd_l)
    else $error("ready shown with byte unread");

  a_ndac_on_take: assert property (@(posedge clk) disable iff (!rst_n)
    (acceptor && st_r.acc == ibi_pkg::ACC_READY && dav_on && !st_r.rx_valid) |=> !bus_oe.ndac_l)
    else $error("accept not shown after take");

  a_idle_silent: assert property (@(posedge clk) disable iff (!rst_n)
    !acceptor |-> !bus_oe.nrfd_l && !bus_oe.ndac_l)
    else $error("unaddressed port in handshake");

  a_cmd_with_atn: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_oe.dav_l && st_r.tx_cmd) |-> bus_oe.atn_l)
    else $error("command byte without attention");

  a_data_no_atn: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_oe.dav_l && !st_r.tx_cmd) |-> !bus_oe.atn_l)
    else $error("data byte under own attention");

  a_srq_watched: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.cic && srq_on) |=> srq_pending)
    else $error("service request missed");

endmodule

// File: verilog/ibi_pkg.sv
/*
 * Package for the instrument bus interface: bus line bundles, roles,
 * handshake states, the state record and timing counts.
 * Assumes a single 50 MHz clock and pins already synchronous to it.
 */
package ibi_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ      = 50;
  localparam int IFC_PULSE_US = 100;
  localparam int IFC_CYCLES   = IFC_PULSE_US * CLK_MHZ;
  localparam int SETTLE_NS    = 100;
  localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int DATA_W       = 8;
  localparam int CTL_W        = 3;
  localparam int MGT_W        = 5;
  localparam int LINE_CNT     = DATA_W + CTL_W + MGT_W;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Level of each bus line as seen on the wire, low means asserted
  typedef struct packed {
    logic [DATA_W-1:0] dio_l;
    logic              dav_l;
    logic              nrfd_l;
    logic              ndac_l;
    logic              atn_l;
    logic              ifc_l;
    logic              ren_l;
    logic              srq_l;
    logic              eoi_l;
  } ibi_bus_type;

  typedef enum logic [1:0] {
    ROLE_IDLE,
    ROLE_CTRL,
    ROLE_TALK,
    ROLE_LISTEN
  } ibi_role_type;

  typedef enum logic [2:0] {
    SRC_IDLE,
    SRC_WAIT_RDY,
    SRC_SETTLE,
    SRC_WAIT_ACC,
    SRC_RELEASE
  } ibi_src_type;

  typedef enum logic [1:0] {
    ACC_READY,
    ACC_TAKE,
    ACC_WAIT_DROP
  } ibi_acc_type;

  typedef struct packed {
    ibi_src_type       src;
    ibi_acc_type       acc;
    logic [15:0]       cnt;
    logic [DATA_W-1:0] tx_byte;
    logic              tx_eoi;
    logic              tx_cmd;
    logic [DATA_W-1:0] rx_byte;
    logic              rx_eoi;
    logic              rx_cmd;
    logic              rx_valid;
    logic              cic;
    logic              ifc_busy;
    logic              ren;
    logic              atn;
    logic              ppoll;
    logic              srq_seen;
  } ibi_state_type;

  localparam logic [15:0] CNT_ZERO = 16'h0000;

endpackage

// File: dv/ibi_instr.sv
/*
 * Cable-side instrument model: acceptor and source of the interlocked
 * handshake, plus attention and service request lines.
 * Assumes a pull-up on every line; oe high pulls the wire low.
 */
`timescale 1ns/1ps
module ibi_instr (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire ibi_pkg::ibi_bus_type bus_w,
  input  wire logic                 acc_en,
  input  wire logic [3:0]           delay,
  input  wire logic                 snd_go,
  input  wire logic [7:0]           snd_byte,
  input  wire logic                 snd_eoi,
  input  wire logic                 snd_atn,
  input  wire logic                 srq_on,
  output ibi_pkg::ibi_bus_type      oe,
  output logic [7:0]                got_byte,
  output logic                      got_eoi,
  output logic                      got_atn,
  output logic [7:0]                got_n,
  output logic                      snd_busy
);
  logic [1:0] acc_st;
  logic [1:0] src_st;
  logic [3:0] wt;
  logic [3:0] sw;
  assign snd_busy = (src_st != 2'h0);
  // ******************
  // Acceptor and source
  // ******************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe <= '0;
      {acc_st, src_st, wt, sw} <= '0;
      {got_byte, got_eoi, got_atn, got_n} <= '0;
    end else begin
      oe.atn_l <= snd_atn;
      oe.srq_l <= srq_on;
      wt <= wt + 4'h1;
      case (acc_st)
        2'h0: begin
          oe.nrfd_l <= acc_en;
          oe.ndac_l <= acc_en;
          if (acc_en && wt >= delay) acc_st <= 2'h1;
        end
        2'h1: begin
          oe.nrfd_l <= 1'b0;
          if (!acc_en) acc_st <= 2'h0;
          else if (bus_w.dav_l == 1'b0) begin
            got_byte <= ~bus_w.dio_l;
            got_eoi <= ~bus_w.eoi_l;
            got_atn <= ~bus_w.atn_l;
            got_n <= got_n + 8'h01;
            oe.nrfd_l <= 1'b1;
            oe.ndac_l <= 1'b0;
            acc_st <= 2'h2;
          end
        end
        default: if (bus_w.dav_l == 1'b1) begin
          oe.ndac_l <= 1'b1;
          wt <= 4'h0;
          acc_st <= 2'h0;
        end
      endcase
      case (src_st)
        2'h0: if (snd_go) src_st <= 2'h1;
        2'h1: if (bus_w.nrfd_l == 1'b1) begin
          oe.dio_l <= snd_byte;
          oe.eoi_l <= snd_eoi;
          sw <= 4'h0;
          src_st <= 2'h2;
        end
        2'h2: begin
          sw <= sw + 4'h1;
          if (sw == 4'h5) begin
            oe.dav_l <= 1'b1;
            src_st <= 2'h3;
          end
        end
        default: if (bus_w.ndac_l == 1'b1) begin
          oe.dav_l <= 1'b0;
          oe.dio_l <= '0;
          oe.eoi_l <= 1'b0;
          src_st <= 2'h0;
        end
      endcase
    end
  end
endmodule

// File: dv/instrument_bus_interface_test.sv
/*
 * Self-checking bench for the instrument bus port: reset, clear, remote
 * enable, transfers both ways, refusals, poll, service request, control pass.
 * Assumes one instrument model on the cable and pull-ups on every line.
 */
`timescale 1ns/1ps
module instrument_bus_interface_test;
  // ******************
  // Bench signals
  // ******************
  localparam int IFCN = 8;
  logic clk, rst_n, sys_ctrl, parity_en, ifc_req, ren_set, ren_clr, cic_pass, ppoll_req;
  logic tx_valid, tx_last, tx_cmd, tx_ready, rx_valid, rx_end, rx_cmd, rx_ready;
  logic cic, srq_pending, ren_active, parity_ok, acc_en, snd_go, snd_eoi, snd_atn, srq_on;
  logic snd_busy, got_eoi, got_atn, dav_q;
  logic [7:0] tx_data, rx_data, snd_byte, got_byte, got_n, dio_q, k;
  logic [3:0] delay;
  ibi_pkg::ibi_role_type role;
  ibi_pkg::ibi_bus_type bus_w, dut_o, dut_oe, prt_oe;
  int n_errors = 0;
  int compares = 0;
  int n_dav = 0;
  int n_ifc = 0;
  int m;
  // Wire low when any party pulls; released lines float high
  assign bus_w = ibi_pkg::ibi_bus_type'(~(dut_oe | prt_oe));
  ibi_core #(.IFC_CYCLES(IFCN)) u_ibi_core (
    .clk(clk), .rst_n(rst_n), .sys_ctrl(sys_ctrl), .role(role), .parity_en(parity_en),
    .ifc_req(ifc_req), .ren_set(ren_set), .ren_clr(ren_clr), .cic_pass(cic_pass),
    .ppoll_req(ppoll_req), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_cmd(tx_cmd), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx_cmd(rx_cmd), .rx_ready(rx_ready), .cic(cic),
    .srq_pending(srq_pending), .ren_active(ren_active), .parity_ok(parity_ok),
    .bus_i(bus_w), .bus_o(dut_o), .bus_oe(dut_oe));
  ibi_instr u_ibi_instr (
    .clk(clk), .rst_n(rst_n), .bus_w(bus_w), .acc_en(acc_en), .delay(delay),
    .snd_go(snd_go), .snd_byte(snd_byte), .snd_eoi(snd_eoi), .snd_atn(snd_atn),
    .srq_on(srq_on), .oe(prt_oe), .got_byte(got_byte), .got_eoi(got_eoi),
    .got_atn(got_atn), .got_n(got_n), .snd_busy(snd_busy));
  always @(posedge clk) begin
    if (bus_w.dav_l === 1'b0) n_dav++;
    if (bus_w.ifc_l === 1'b0) n_ifc++;
    if (bus_w.dav_l === 1'b0 && dav_q === 1'b0 && bus_w.dio_l !== dio_q) bad("data moved under valid");
    dav_q <= bus_w.dav_l;
    dio_q <= bus_w.dio_l;
  end
  // ******************
  // Helpers
  // ******************
  task automatic bad(input string s);
    n_errors++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input bit ok, input string s);
    compares++;
    if (!ok) bad(s);
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 400) begin
      @(negedge clk);
      i++;
    end
    if (s !== v) bad("wait timed out");
  endtask
  task automatic send(input logic [7:0] d, input logic c, input logic last);
    wait_for(tx_ready, 1'b1);
    {tx_data, tx_cmd, tx_last, tx_valid} = {d, c, last, 1'b1};
    tick(1);
    tx_valid = 1'b0;
    tick(1);
    wait_for(tx_ready, 1'b1);
  endtask
  task automatic psend(input logic [7:0] d, input logic e, input logic a);
    {snd_byte, snd_eoi, snd_atn, snd_go} = {d, e, a, 1'b1};
    tick(1);
    snd_go = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(3);
  endtask
  // ******************
  // Scenarios
  // ******************
  task automatic t_reset;
    chk(tx_ready === 1'b1 && rx_valid === 1'b0 && cic === 1'b0, "reset outputs");
    chk(dut_oe === '0 && dut_o === '0 && bus_w === '1, "lines idle high");
  endtask
  task automatic t_recv;
    role = ibi_pkg::ROLE_LISTEN;
    {parity_en, rx_ready} = 2'b10;
    psend(8'h5A, 1'b1, 1'b0);
    wait_for(rx_valid, 1'b1);
    chk(rx_data === 8'h5A && rx_end === 1'b1 && rx_cmd === 1'b0, "data byte");
    chk(parity_ok === 1'b1, "parity");
    tick(6);
    chk(rx_valid === 1'b1 && bus_w.nrfd_l === 1'b0, "busy while unread");
    pulse(rx_ready);
    wait_for(snd_busy, 1'b0);
    tick(2);
    chk(rx_valid === 1'b0 && bus_w.ndac_l === 1'b0, "accept reset");
    role = ibi_pkg::ROLE_IDLE;
    psend(8'h33, 1'b0, 1'b0);
    wait_for(snd_busy, 1'b0);
    tick(2);
    chk(rx_valid === 1'b0, "unaddressed took data");
    psend(8'h23, 1'b0, 1'b1);
    wait_for(rx_valid, 1'b1);
    chk(rx_cmd === 1'b1 && rx_data === 8'h23, "command byte");
    chk(parity_ok === 1'b0, "odd parity missed");
    rx_ready = 1'b1;
    wait_for(snd_busy, 1'b0);
    snd_atn = 1'b0;
    tick(2);
  endtask
  task automatic t_ren;
    pulse(ren_set);
    chk(ren_active === 1'b0 && bus_w.ren_l === 1'b1, "remote without system role");
    sys_ctrl = 1'b1;
    pulse(ren_set);
    chk(ren_active === 1'b1 && bus_w.ren_l === 1'b0, "remote set");
    pulse(ren_clr);
    chk(ren_active === 1'b0 && bus_w.ren_l === 1'b1, "remote clear");
  endtask
  task automatic t_ifc;
    sys_ctrl = 1'b0;
    m = n_ifc;
    pulse(ifc_req);
    chk(n_ifc == m && cic === 1'b0, "clear without system role");
    sys_ctrl = 1'b1;
    pulse(ifc_req);
    tick(IFCN + 4);
    chk(n_ifc - m == IFCN, "clear width");
    chk(cic === 1'b1, "not in charge");
  endtask
  task automatic t_cmd;
    {acc_en, delay} = {1'b1, 4'h3};
    k = got_n;
    send(8'h3F, 1'b1, 1'b0);
    chk(got_n === k + 8'h01 && got_byte === 8'h3F && got_atn === 1'b1, "command out");
    tx_cmd = 1'b0;
    tick(2);
    chk(bus_w.atn_l === 1'b1, "attention held");
  endtask
  task automatic t_data;
    role = ibi_pkg::ROLE_TALK;
    send(8'hA5, 1'b0, 1'b1);
    chk(got_byte === 8'hA5 && got_eoi === 1'b1 && got_atn === 1'b0, "last data");
    delay = 4'h0;
    send(8'h80, 1'b0, 1'b0);
    chk(got_byte === 8'h80 && got_eoi === 1'b0 && got_n === k + 8'h03, "top bit");
  endtask
  task automatic t_refuse;
    role = ibi_pkg::ROLE_LISTEN;
    m = n_dav;
    send(8'h11, 1'b0, 1'b0);
    tick(10);
    chk(n_dav == m && tx_ready === 1'b1, "data refused");
  endtask
  task automatic t_mgmt;
    srq_on = 1'b1;
    tick(3);
    chk(srq_pending === 1'b1, "service request");
    srq_on = 1'b0;
    ppoll_req = 1'b1;
    tick(3);
    chk(bus_w.atn_l === 1'b0 && bus_w.eoi_l === 1'b0, "parallel poll");
    ppoll_req = 1'b0;
    tick(2);
    pulse(cic_pass);
    chk(cic === 1'b0, "control kept");
    m = n_dav;
    send(8'h22, 1'b1, 1'b0);
    tick(10);
    chk(n_dav == m, "command without charge");
    tx_cmd = 1'b0;
    role = ibi_pkg::ROLE_TALK;
    send(8'h42, 1'b0, 1'b0);
    chk(got_byte === 8'h42 && got_atn === 1'b0 && cic === 1'b0, "talk only");
  endtask
  // ******************
  // Run
  // ******************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    bad("watchdog");
    report_and_stop();
  end
  initial begin
    {rst_n, sys_ctrl, parity_en, ifc_req, ren_set, ren_clr, cic_pass, ppoll_req} = '0;
    {tx_valid, tx_data, tx_last, tx_cmd, rx_ready, acc_en, delay} = '0;
    {snd_go, snd_byte, snd_eoi, snd_atn, srq_on} = '0;
    role = ibi_pkg::ROLE_IDLE;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_recv();
    t_ren();
    t_ifc();
    t_cmd();
    t_data();
    t_refuse();
    t_mgmt();
    report_and_stop();
  end
endmodule
